// ---- tpwm_cfg.svh ----
// register map, field positions, reset values and prescale masks of the timer pwm block
`ifndef TPWM_CFG_SVH
`define TPWM_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TPWM_OFF_CTRL    8'h00
`define TPWM_OFF_COUNT   8'h04
`define TPWM_OFF_CMPA    8'h08
`define TPWM_OFF_CMPB    8'h0C
`define TPWM_OFF_CAPTOP  8'h10
`define TPWM_OFF_FLAGS   8'h14
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TPWM_F_WMODE     3:0
`define TPWM_F_OMA       5:4
`define TPWM_F_OMB       7:6
`define TPWM_F_PRESC     10:8
`define TPWM_B_DIRA      12
`define TPWM_B_DIRB      13
`define TPWM_B_LVLA      14
`define TPWM_B_LVLB      15
// ----------------------------------------------------------------
// flag register bits
// ----------------------------------------------------------------
`define TPWM_B_OVF       0
`define TPWM_B_CMPA      1
`define TPWM_B_CMPB      2
`define TPWM_B_CAPT      3
// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define TPWM_RST16       16'h0000
`define TPWM_MAX         16'hFFFF
`define TPWM_TOP8        16'h00FF
`define TPWM_TOP9        16'h01FF
`define TPWM_TOP10       16'h03FF
`define TPWM_PS_M1       10'h000
`define TPWM_PS_M8       10'h007
`define TPWM_PS_M64      10'h03F
`define TPWM_PS_M256     10'h0FF
`define TPWM_PS_M1024    10'h3FF
`define TPWM_RESP_OK     2'h0
`define TPWM_RESP_ERR    2'h2
`endif

// ---- tpwm_pkg.sv ----
// types shared by the timer pwm block
package tpwm_pkg;
  typedef enum logic [3:0] {
    WM_NORMAL  = 4'h0,
    WM_CTC_A   = 4'h4,
    WM_FAST8   = 4'h5,
    WM_FAST9   = 4'h6,
    WM_FAST10  = 4'h7,
    WM_CTC_CAP = 4'hC,
    WM_FAST_CAP = 4'hE,
    WM_FAST_A  = 4'hF
  } tpwm_wmode_t;
  typedef enum logic [1:0] {
    OM_OFF    = 2'h0,
    OM_TOGGLE = 2'h1,
    OM_NONINV = 2'h2,
    OM_INV    = 2'h3
  } tpwm_omode_t;
  typedef enum logic [2:0] {
    PS_STOP = 3'h0,
    PS_1    = 3'h1,
    PS_8    = 3'h2,
    PS_64   = 3'h3,
    PS_256  = 3'h4,
    PS_1024 = 3'h5
  } tpwm_presc_t;
endpackage

// ---- tpwm_prescale.sv ----
// prescaler that turns the system clock into one-cycle timer ticks
`timescale 1ns/1ps
`include "tpwm_cfg.svh"
module tpwm_prescale (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // divide select and tick
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [9:0] div_r;
  logic [9:0] mask;

  always_comb begin
    unique case (sel)
      tpwm_pkg::PS_1:    mask = `TPWM_PS_M1;
      tpwm_pkg::PS_8:    mask = `TPWM_PS_M8;
      tpwm_pkg::PS_64:   mask = `TPWM_PS_M64;
      tpwm_pkg::PS_256:  mask = `TPWM_PS_M256;
      default:           mask = `TPWM_PS_M1024;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) div_r <= 10'h000;
    else     div_r <= div_r + 10'h001;
  end

  // stop and the two unused codes give no tick at all
  always_ff @(posedge mclk) begin
    if (rst) tick <= 1'b0;
    else     tick <= (sel != tpwm_pkg::PS_STOP) && (sel <= tpwm_pkg::PS_1024) && ((div_r & mask) == mask);
  end
endmodule // tpwm_prescale

// ---- tpwm_top.sv ----
// 16-bit timer with clear-on-match and fast pwm waveforms behind an axi4-lite slave
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "tpwm_cfg.svh"
module tpwm_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // compare output pins
  output logic             pin_a_out,
  output logic             pin_a_oe_n,
  output logic             pin_b_out,
  output logic             pin_b_oe_n
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] ctrl_r, count_r, cmpa_buf_r, cmpa_act_r, cmpb_buf_r, cmpb_act_r, captop_r;
  logic [3:0]  flags_r;
  logic        block_r, oc_a_r, oc_b_r;
  logic        aw_got_r, w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        tick, wr_do, wr_ok;
  logic [7:0]  waddr;
  logic [3:0]  wmode;
  logic [1:0]  om_a, om_b;
  logic        is_ctc, is_fast, is_fixed, at_top, match_a, match_b, bottom;
  logic [15:0] top;
  logic        wr_ctrl, wr_count, wr_cmpa, wr_cmpb, wr_cap, wr_flags;
  logic [3:0]  flag_set;
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction
  // one output compare unit; bottom takes priority over match in fast pwm
  function automatic logic oc_next(input logic cur, input logic [1:0] om, input logic fast,
                                   input logic tog_ok, input logic match, input logic bot);
    oc_next = cur;
    if (fast) begin
      unique case (om)
        tpwm_pkg::OM_NONINV: oc_next = bot ? 1'b1 : (match ? 1'b0 : cur);
        tpwm_pkg::OM_INV:    oc_next = bot ? 1'b0 : (match ? 1'b1 : cur);
        tpwm_pkg::OM_TOGGLE: oc_next = (tog_ok && match) ? ~cur : cur;
        tpwm_pkg::OM_OFF:    oc_next = cur;
      endcase
    end else if (match) begin
      unique case (om)
        tpwm_pkg::OM_TOGGLE: oc_next = ~cur;
        tpwm_pkg::OM_NONINV: oc_next = 1'b0;
        tpwm_pkg::OM_INV:    oc_next = 1'b1;
        tpwm_pkg::OM_OFF:    oc_next = cur;
      endcase
    end
  endfunction
  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  tpwm_prescale u_presc (
    .mclk (mclk),
    .rst  (rst),
    .sel  (ctrl_r[`TPWM_F_PRESC]),
    .tick (tick)
  );
  // ----------------------------------------------------------------
  // mode decode and top selection
  // ----------------------------------------------------------------
  assign wmode    = ctrl_r[`TPWM_F_WMODE];
  assign om_a     = ctrl_r[`TPWM_F_OMA];
  assign om_b     = ctrl_r[`TPWM_F_OMB];
  assign is_ctc   = (wmode == tpwm_pkg::WM_CTC_A) || (wmode == tpwm_pkg::WM_CTC_CAP);
  assign is_fixed = (wmode == tpwm_pkg::WM_FAST8) || (wmode == tpwm_pkg::WM_FAST9) ||
                    (wmode == tpwm_pkg::WM_FAST10);
  assign is_fast  = is_fixed || (wmode == tpwm_pkg::WM_FAST_CAP) || (wmode == tpwm_pkg::WM_FAST_A);
  always_comb begin
    unique case (wmode)
      tpwm_pkg::WM_CTC_A, tpwm_pkg::WM_FAST_A:     top = cmpa_act_r;
      tpwm_pkg::WM_CTC_CAP, tpwm_pkg::WM_FAST_CAP: top = captop_r;
      tpwm_pkg::WM_FAST8:                          top = `TPWM_TOP8;
      tpwm_pkg::WM_FAST9:                          top = `TPWM_TOP9;
      tpwm_pkg::WM_FAST10:                         top = `TPWM_TOP10;
      default:                                     top = `TPWM_MAX;
    endcase
  end
  // a count that has passed a lowered top only meets it again after wrapping
  assign at_top  = (is_ctc || is_fast) && (count_r == top);
  assign bottom  = is_fast && tick && at_top;
  assign match_a = tick && !block_r && (count_r == cmpa_act_r);
  assign match_b = tick && !block_r && (count_r == cmpb_act_r);
  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  assign wr_do    = aw_got_r && w_got_r && !s_axi_bvalid;
  assign waddr    = {awaddr_r[7:2], 2'b00};
  assign wr_ctrl  = wr_do && (waddr == `TPWM_OFF_CTRL);
  assign wr_count = wr_do && (waddr == `TPWM_OFF_COUNT);
  assign wr_cmpa  = wr_do && (waddr == `TPWM_OFF_CMPA);
  assign wr_cmpb  = wr_do && (waddr == `TPWM_OFF_CMPB);
  assign wr_cap   = wr_do && (waddr == `TPWM_OFF_CAPTOP);
  assign wr_flags = wr_do && (waddr == `TPWM_OFF_FLAGS);
  assign wr_ok    = wr_ctrl || wr_count || wr_cmpa || wr_cmpb || wr_cap || wr_flags;
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_do) begin
        w_got_r <= 1'b0;
      end
      // ready only while the channel is empty and no response is pending
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !wr_do;
      s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !wr_do;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TPWM_RESP_OK;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `TPWM_RESP_OK : `TPWM_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TPWM_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `TPWM_RESP_OK;
        unique case ({s_axi_araddr[7:2], 2'b00})
          `TPWM_OFF_CTRL:   s_axi_rdata <= {16'h0000, ctrl_r};
          `TPWM_OFF_COUNT:  s_axi_rdata <= {16'h0000, count_r};
          `TPWM_OFF_CMPA:   s_axi_rdata <= {16'h0000, cmpa_buf_r};
          `TPWM_OFF_CMPB:   s_axi_rdata <= {16'h0000, cmpb_buf_r};
          `TPWM_OFF_CAPTOP: s_axi_rdata <= {16'h0000, captop_r};
          `TPWM_OFF_FLAGS:  s_axi_rdata <= {28'h000_0000, flags_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TPWM_RESP_ERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // control, top and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst)          ctrl_r <= `TPWM_RST16;
    else if (wr_ctrl) ctrl_r <= merge16(ctrl_r, wdata_r, wstrb_r);
  end
  // capture top takes effect at once in every mode
  always_ff @(posedge mclk) begin
    if (rst)         captop_r <= `TPWM_RST16;
    else if (wr_cap) captop_r <= merge16(captop_r, wdata_r, wstrb_r);
  end
  // buffered in fast pwm, written through otherwise
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmpa_buf_r <= `TPWM_RST16;
      cmpa_act_r <= `TPWM_RST16;
      cmpb_buf_r <= `TPWM_RST16;
      cmpb_act_r <= `TPWM_RST16;
    end else begin
      if (wr_cmpa) cmpa_buf_r <= merge16(cmpa_buf_r, wdata_r, wstrb_r) & (is_fixed ? top : `TPWM_MAX);
      if (wr_cmpb) cmpb_buf_r <= merge16(cmpb_buf_r, wdata_r, wstrb_r) & (is_fixed ? top : `TPWM_MAX);
      if (!is_fast && wr_cmpa)
        cmpa_act_r <= merge16(cmpa_buf_r, wdata_r, wstrb_r);
      else if (bottom)
        cmpa_act_r <= cmpa_buf_r;
      if (!is_fast && wr_cmpb)
        cmpb_act_r <= merge16(cmpb_buf_r, wdata_r, wstrb_r);
      else if (bottom)
        cmpb_act_r <= cmpb_buf_r;
    end
  end
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a software write beats the tick and masks matches for the next tick
  always_ff @(posedge mclk) begin
    if (rst)                count_r <= `TPWM_RST16;
    else if (wr_count)      count_r <= merge16(count_r, wdata_r, wstrb_r);
    else if (tick && at_top) count_r <= `TPWM_RST16;
    else if (tick)          count_r <= count_r + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (rst)           block_r <= 1'b0;
    else if (wr_count) block_r <= 1'b1;
    else if (tick)     block_r <= 1'b0;
  end
  // ----------------------------------------------------------------
  // flags: hardware set wins over a write-one-to-clear
  // ----------------------------------------------------------------
  always_comb begin
    flag_set              = 4'h0;
    flag_set[`TPWM_B_OVF] = tick && (is_fast ? at_top : (count_r == `TPWM_MAX));
    flag_set[`TPWM_B_CMPA] = match_a || (bottom && (wmode == tpwm_pkg::WM_FAST_A));
    flag_set[`TPWM_B_CMPB] = match_b;
    flag_set[`TPWM_B_CAPT] = tick && at_top && ((wmode == tpwm_pkg::WM_CTC_CAP) ||
                                               (wmode == tpwm_pkg::WM_FAST_CAP));
  end
  always_ff @(posedge mclk) begin
    if (rst)           flags_r <= 4'h0;
    else if (wr_flags) flags_r <= (flags_r & ~(wdata_r[3:0] & {4{wstrb_r[0]}})) | flag_set;
    else               flags_r <= flags_r | flag_set;
  end
  // ----------------------------------------------------------------
  // waveform and pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      oc_a_r <= 1'b0;
      oc_b_r <= 1'b0;
    end else begin
      oc_a_r <= oc_next(oc_a_r, om_a, is_fast, wmode == tpwm_pkg::WM_FAST_A, match_a, bottom);
      oc_b_r <= oc_next(oc_b_r, om_b, is_fast, 1'b0, match_b, bottom);
    end
  end
  // mode zero hands the pin back to its plain port level
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_a_out  <= 1'b0;
      pin_a_oe_n <= 1'b1;
      pin_b_out  <= 1'b0;
      pin_b_oe_n <= 1'b1;
    end else begin
      pin_a_out  <= (om_a != tpwm_pkg::OM_OFF) ? oc_a_r : ctrl_r[`TPWM_B_LVLA];
      pin_a_oe_n <= !ctrl_r[`TPWM_B_DIRA];
      pin_b_out  <= (om_b != tpwm_pkg::OM_OFF) ? oc_b_r : ctrl_r[`TPWM_B_LVLB];
      pin_b_oe_n <= !ctrl_r[`TPWM_B_DIRB];
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ctc_clear_zero: assert property (tick && is_ctc && at_top && !wr_count |=> count_r == 16'h0000)
    else $error("clear-on-match did not clear the count");
  a_ctc_top_flag: assert property (tick && at_top && wmode == tpwm_pkg::WM_CTC_CAP |=> flags_r[`TPWM_B_CAPT])
    else $error("capture flag missing at top");
  a_cap_unbuffered: assert property (wr_cap && wstrb_r[1:0] == 2'h3 |=> captop_r == $past(wdata_r[15:0]))
    else $error("capture top not written through");
  a_ctc_toggle: assert property (!is_fast && om_a == tpwm_pkg::OM_TOGGLE && match_a |=> oc_a_r != $past(oc_a_r))
    else $error("output a did not toggle");
  a_pin_release: assert property (!ctrl_r[`TPWM_B_DIRA] |=> pin_a_oe_n)
    else $error("pin a driven while direction is input");
  a_ovf_wrap: assert property (tick && !is_fast && count_r == 16'hFFFF && !wr_count
                               |=> flags_r[`TPWM_B_OVF] && count_r == 16'h0000)
    else $error("overflow not flagged on wrap");
  a_fast_restart: assert property (bottom && !wr_count |=> count_r == 16'h0000 && flags_r[`TPWM_B_OVF])
    else $error("fast pwm did not restart at top");
  a_fast_set_bot: assert property (bottom && om_a == tpwm_pkg::OM_NONINV |=> oc_a_r)
    else $error("non-inverting output not set at bottom");
  // a mode change right after bottom may hand the pin back, so the pin is checked on its own
  a_pin_follow: assert property (om_a != tpwm_pkg::OM_OFF |=> pin_a_out == $past(oc_a_r))
    else $error("pin a does not show waveform a");
  a_buffer_load: assert property (bottom && !wr_cmpa |=> cmpa_act_r == $past(cmpa_buf_r))
    else $error("compare a buffer not loaded at top");
  a_fixed_mask: assert property (wr_cmpa && wmode == tpwm_pkg::WM_FAST8 |=> cmpa_buf_r[15:8] == 8'h00)
    else $error("compare bits above fixed top not masked");
  c_fast_toggle: cover property (wmode == tpwm_pkg::WM_FAST_A && om_a == tpwm_pkg::OM_TOGGLE && match_a);
  c_ctc_wrap: cover property (tick && is_ctc && count_r == 16'hFFFF);
  c_fast_period: cover property (bottom ##[1:300] bottom);
endmodule // tpwm_top

// ---- tpwm_top_tb.sv ----
// self-checking testbench for the timer pwm block over its axi4-lite registers
`timescale 1ns/1ps
`include "tpwm_cfg.svh"
module tpwm_top_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0]  rsp;
  logic        pa, pa_oe_n, pb, pb_oe_n;
  int          bad_count = 0, samples_checked = 0, hi, i;
  int          ps_div [1:5] = '{1, 8, 64, 256, 1024};
  // fast pwm 8-bit table: output mode, compare value, high samples over two 256-cycle periods
  logic [1:0]  f8_om [6] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h0};
  logic [15:0] f8_cv [6] = '{16'h0010, 16'h0010, 16'h0000, 16'h00FF, 16'h00FF, 16'h0010};
  int          f8_hi [6] = '{34, 478, 2, 512, 0, 0};
  tpwm_top u_dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_a_out(pa),
    .pin_a_oe_n(pa_oe_n), .pin_b_out(pb), .pin_b_oe_n(pb_oe_n));
  initial forever #2 mclk = ~mclk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang();
    bad_count++;
    $display("[ERR] bus wait expected answer seen none");
    conclude();
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (awvalid && awready) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin wd = 1'b1; wvalid <= 1'b0; end
      if (ad && wd && bvalid) begin r = bresp; bready <= 1'b0; break; end
    end
    if (n == 100) hang();
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ad;
    ad = 1'b0;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (arvalid && arready) begin ad = 1'b1; arvalid <= 1'b0; end
      if (ad && rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
    end
    if (n == 100) hang();
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
  endtask
  function automatic logic [31:0] ctrl(input logic [3:0] wm, input logic [1:0] om, input logic [2:0] ps,
                                       input logic dir);
    ctrl = {16'h0000, 3'b000, dir, 1'b0, ps, 2'b00, om, wm};
  endfunction
  // mode change also restarts the count, so a stale count above a new top never wraps via max
  task automatic mode(input logic [3:0] wm, input logic [1:0] om, input logic [2:0] ps);
    w(`TPWM_OFF_CTRL, ctrl(wm, om, ps, 1'b1));
    w(`TPWM_OFF_COUNT, 32'h00000000);
  endtask
  // high samples of pin a over a window of whole periods, independent of phase
  task automatic count_high(input int settle, input int win);
    repeat (settle) @(posedge mclk);
    hi = 0;
    repeat (win) begin
      @(posedge mclk);
      hi += (pa === 1'b1) ? 1 : 0;
    end
  endtask
  task automatic flags_after(input int t);
    repeat (200) @(posedge mclk);
    w(`TPWM_OFF_FLAGS, 32'h0000000F);
    repeat (t) @(posedge mclk);
    rdr(`TPWM_OFF_FLAGS, rd, rsp);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check("oe_a reset", {31'h0, pa_oe_n}, 32'h1);
    check("oe_b reset", {31'h0, pb_oe_n}, 32'h1);
    rdr(`TPWM_OFF_CTRL, rd, rsp);
    check("ctrl reset", rd, 32'h0);
    rdr(8'h3C, rd, rsp);
    check("unmapped rresp", {30'h0, rsp}, {30'h0, `TPWM_RESP_ERR});
    wr(8'h3C, 32'h0000FFFF, rsp);
    check("unmapped bresp", {30'h0, rsp}, {30'h0, `TPWM_RESP_ERR});
    $display("test reset_and_map done");
    for (i = 0; i < 3; i++) begin
      w(`TPWM_OFF_CTRL, ctrl(4'h5 + i[3:0], 2'h0, 3'h0, 1'b0));
      w(`TPWM_OFF_CMPA, 32'h0000FFFF);
      rdr(`TPWM_OFF_CMPA, rd, rsp);
      check("cmpa masked", rd, (32'h100 << i) - 32'h1);
    end
    $display("test fixed_top_mask done");
    w(`TPWM_OFF_CMPB, 32'h00000005);
    // fast pwm 8-bit: {output mode, compare, high samples over two 256-cycle periods}
    for (i = 0; i < 6; i++) begin
      w(`TPWM_OFF_CMPA, {16'h0000, f8_cv[i]});
      mode(tpwm_pkg::WM_FAST8, f8_om[i], tpwm_pkg::PS_1);
      count_high(600, 512);
      check("fast8 high count", hi, f8_hi[i]);
    end
    check("oe_a driven", {31'h0, pa_oe_n}, 32'h0);
    check("pin_b plain level", {31'h0, pb}, 32'h0);
    check("oe_b still input", {31'h0, pb_oe_n}, 32'h1);
    $display("test fast8_duty done");
    w(`TPWM_OFF_CMPA, 32'h00000020);
    mode(tpwm_pkg::WM_FAST_A, tpwm_pkg::OM_TOGGLE, tpwm_pkg::PS_1);
    count_high(200, 132);
    check("fast_a toggle", hi, 66);
    flags_after(100);
    check("fast_a flags", rd, 32'h7);
    w(`TPWM_OFF_CAPTOP, 32'h00000020);
    mode(tpwm_pkg::WM_FAST_CAP, tpwm_pkg::OM_NONINV, tpwm_pkg::PS_1);
    flags_after(100);
    check("fast_cap flags", rd, 32'hF);
    mode(tpwm_pkg::WM_CTC_CAP, tpwm_pkg::OM_OFF, tpwm_pkg::PS_1);
    flags_after(100);
    check("ctc_cap flags", rd, 32'hE);
    $display("test top_flags done");
    w(`TPWM_OFF_CMPA, 32'h00000000);
    for (i = 1; i <= 5; i++) begin
      mode(tpwm_pkg::WM_CTC_A, tpwm_pkg::OM_TOGGLE, i[2:0]);
      count_high(2 * ps_div[i], 4 * ps_div[i]);
      check("ctc toggle high", hi, 2 * ps_div[i]);
    end
    $display("test ctc_prescale done");
    w(`TPWM_OFF_CMPA, 32'h00000020);
    // back to a tick every cycle, else the wrap lies thousands of cycles away
    w(`TPWM_OFF_CTRL, ctrl(4'h4, 2'h1, 3'h1, 1'b1));
    w(`TPWM_OFF_COUNT, 32'h0000FFF0);
    w(`TPWM_OFF_FLAGS, 32'h0000000F);
    repeat (25) @(posedge mclk);
    rdr(`TPWM_OFF_FLAGS, rd, rsp);
    check("ctc wrap flags", rd & 32'h3, 32'h1);
    w(`TPWM_OFF_CTRL, ctrl(4'h4, 2'h1, 3'h1, 1'b0));
    repeat (3) @(posedge mclk);
    check("oe_a released", {31'h0, pa_oe_n}, 32'h1);
    $display("test ctc_wrap done");
    conclude();
  end
endmodule // tpwm_top_tb
